// >>> rtl/ddrp_defines.svh
// ddrp_defines.svh: constants of the ddr burst-of-four sram port
`ifndef DDRP_DEFINES_SVH
`define DDRP_DEFINES_SVH
// ============================================================
// widths
`define DDRP_DW 36
`define DDRP_AW 17
`define DDRP_LANE_W 9
// ============================================================
// timing and depth
`define DDRP_LOCK_CYCLES 2048
`define DDRP_FIFO_DEPTH 8
`define DDRP_RPIPE 4
`define DDRP_STG_FULL 2'h1
`define DDRP_STG_BYPASS 2'h0
// ============================================================
// beat numbers inside a burst of four
`define DDRP_BEAT0 2'h0
`define DDRP_BEAT1 2'h1
`define DDRP_BEAT2 2'h2
`define DDRP_BEAT3 2'h3
`define DDRP_EVEN 1'h0
`define DDRP_ODD 1'h1
`endif

// >>> rtl/ddrp_pkg.sv
// ddrp_pkg: shared types of the ddr burst-of-four sram port
package ddrp_pkg;
    typedef enum logic [1:0]
    {
        ddrp_dll_bypass,
        ddrp_dll_locking,
        ddrp_dll_locked
    } ddrp_dll_state_t;
endpackage : ddrp_pkg

// >>> rtl/ddrp_stream_if.sv
// ddrp_stream_if: valid/ready word stream between port and buffer
interface ddrp_stream_if
#(
    parameter int W = 8
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ddrp_stream_if

// >>> rtl/ddrp_fifo.sv
// ddrp_fifo: synchronous write buffer with valid/ready on both sides
`include "ddrp_defines.svh"
module ddrp_fifo
#(
    parameter int W = 8,
    parameter int DEPTH = `DDRP_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // filling side
    ddrp_stream_if.snk fill,
    // draining side
    ddrp_stream_if.src drain
);
    import ddrp_pkg::*;

    // pointers wrap naturally, so depth must be a power of two
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] store [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign fill.ready = count_reg != (PW + 1)'(DEPTH);
    assign drain.valid = count_reg != '0;
    assign drain.data = store[rd_ptr_reg];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_ff @(posedge clk)
    begin
        if (push)
            store[wr_ptr_reg] <= fill.data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg + PW'(push);
            rd_ptr_reg <= rd_ptr_reg + PW'(pop);
            count_reg <= count_reg + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    // ============================================================
    // checks
    a_fifo_count_up:
    assert property (
        @(posedge clk) disable iff (!rst_n)
        push && !pop |=> count_reg == $past(count_reg) + 1'b1
    ) else $error("buffer count did not follow a push");

    c_fifo_full: cover property (
        @(posedge clk) disable iff (!rst_n) !fill.ready ##1 pop
    );
endmodule : ddrp_fifo

// >>> rtl/ddrp_port.sv
// ddrp_port: pin-level port logic of the burst-of-four ddr sram
//
// Functional notes
// - address and command taken on true-clock rise
// - echo clocks toggle continuously, even when idle
// - echo clock edges aligned with data edges
// - dll control low bypasses and clears lock
// - dll locks after lock time once enabled
// - dll off gives shorter read latency
// - valid flag high exactly while read data driven
// - address registered only when a cycle loads
// - write beats sampled on both clock rises
// - reads drive bus in step with echo clocks
// - data width 18 or 36 by parameter
// - load low: select high reads, low writes
// - byte lane written only with strobe low
// - first read beat 2.5 cycles after command with dll locked, 1.5 in bypass
`include "ddrp_defines.svh"
module ddrp_port
#(
    parameter int DW = `DDRP_DW,
    parameter int AW = `DDRP_AW,
    parameter int LOCK_CYCLES = `DDRP_LOCK_CYCLES,
    parameter int FIFO_DEPTH = `DDRP_FIFO_DEPTH
)
(
    // core clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // input clock pair from the controller
    input wire logic k_clk,
    input wire logic k_clk_n,
    // command pins
    input wire logic load_cycle_n,
    input wire logic rw_sel,
    input wire logic [AW-1:0] addr_in,
    // shared data bus and byte strobes
    input wire logic [DW-1:0] data_io_in,
    output logic [DW-1:0] data_io_out,
    output logic data_io_oe,
    input wire logic [DW/`DDRP_LANE_W-1:0] byte_write_n,
    // echo clocks and read valid
    output logic echo_clk_true,
    output logic echo_clk_comp,
    output logic out_valid_flag,
    // dll control and status, write buffer ready
    input wire logic dll_off_n,
    output ddrp_pkg::ddrp_dll_state_t dll_status,
    output logic wr_buf_ready
);
    import ddrp_pkg::*;

    localparam int LW = `DDRP_LANE_W;
    localparam int BW = DW / LW;
    localparam int LCW = $clog2(LOCK_CYCLES + 1);
    localparam int WW = AW + 1 + 2 * (DW + BW);
    localparam int RP = `DDRP_RPIPE;

    // ============================================================
    // dll control, core clock domain
    logic [1:0] doff_sync_reg;
    ddrp_dll_state_t dll_state_reg;
    logic [LCW-1:0] lock_cnt_reg;
    logic dll_lock_reg;
    logic lock_done;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            doff_sync_reg <= 2'h0;
        else
            doff_sync_reg <= {doff_sync_reg[0], dll_off_n};
    end

    assign lock_done = lock_cnt_reg == LCW'(LOCK_CYCLES - 1);

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dll_state_reg <= ddrp_dll_bypass;
            lock_cnt_reg <= '0;
        end
        else
        begin
            case (dll_state_reg)
                ddrp_dll_bypass:
                begin
                    // lock history is dropped while bypassed
                    lock_cnt_reg <= '0;
                    if (doff_sync_reg[1])
                        dll_state_reg <= ddrp_dll_locking;
                end
                ddrp_dll_locking:
                begin
                    if (!doff_sync_reg[1])
                        dll_state_reg <= ddrp_dll_bypass;
                    else if (lock_done)
                        dll_state_reg <= ddrp_dll_locked;
                    else
                        lock_cnt_reg <= lock_cnt_reg + LCW'(1);
                end
                ddrp_dll_locked:
                begin
                    if (!doff_sync_reg[1])
                        dll_state_reg <= ddrp_dll_bypass;
                end
                default:
                    dll_state_reg <= ddrp_dll_bypass;
            endcase
        end
    end

    // single flop so the crossing never sees a decode glitch
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            dll_lock_reg <= 1'h0;
        else
            dll_lock_reg <= doff_sync_reg[1] &&
                ((dll_state_reg == ddrp_dll_locking && lock_done) ||
                dll_state_reg == ddrp_dll_locked);
    end

    assign dll_status = dll_state_reg;

    // ============================================================
    // link domain reset and lock crossing
    logic [1:0] krst_sync_reg;
    logic k_rst_n;
    logic [1:0] lock_sync_reg;

    always_ff @(posedge k_clk or negedge rstn)
    begin
        if (!rstn)
            krst_sync_reg <= 2'h0;
        else
            krst_sync_reg <= {krst_sync_reg[0], 1'h1};
    end

    assign k_rst_n = krst_sync_reg[1];

    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
            lock_sync_reg <= 2'h0;
        else
            lock_sync_reg <= {lock_sync_reg[0], dll_lock_reg};
    end

    // ============================================================
    // command capture on the true clock rise
    logic busy_reg;
    logic load_ok;
    logic rd_issue;
    logic wr_issue;
    logic [RP-1:0] rsh_reg;
    logic [AW-1:0] ra_reg [RP];
    logic mode_reg;

    // a load on the edge right after an accepted one is ignored
    assign load_ok = !load_cycle_n && !busy_reg;
    assign rd_issue = load_ok && rw_sel;
    assign wr_issue = load_ok && !rw_sel;

    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            busy_reg <= 1'h0;
            rsh_reg <= '0;
            for (int i = 0; i < RP; i++)
                ra_reg[i] <= '0;
        end
        else
        begin
            busy_reg <= load_ok;
            rsh_reg <= {rsh_reg[RP-2:0], rd_issue};
            if (load_ok)
                ra_reg[0] <= addr_in;
            for (int i = 1; i < RP; i++)
                ra_reg[i] <= ra_reg[i-1];
        end
    end

    // latency mode only switches while no read is in flight
    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
            mode_reg <= 1'h0;
        else if (rsh_reg == '0 && !rd_issue)
            mode_reg <= lock_sync_reg[1];
    end

    // ============================================================
    // read beat scheduling
    logic [1:0] ofs;
    logic rd_first;
    logic rd_second;
    logic rd_third;
    logic rd_fetch;
    logic [DW-1:0] mem [2 ** (AW + 2)];
    logic [DW-1:0] q_k_reg;
    logic [DW-1:0] q_kn_reg;
    logic [DW-1:0] kn_stage_reg;
    logic valid_k_reg;
    logic valid_kn_reg;
    logic kn_vstage_reg;

    // bypass mode pulls every beat one cycle earlier
    assign ofs = mode_reg ? `DDRP_STG_FULL : `DDRP_STG_BYPASS;
    assign rd_first = rsh_reg[ofs];
    assign rd_second = rsh_reg[ofs + 2'h1];
    assign rd_third = rsh_reg[ofs + 2'h2];
    assign rd_fetch = rd_first || rd_second || rd_third;

    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            q_k_reg <= '0;
            kn_stage_reg <= '0;
            valid_k_reg <= 1'h0;
            kn_vstage_reg <= 1'h0;
        end
        else
        begin
            valid_k_reg <= rd_second || rd_third;
            kn_vstage_reg <= rd_first || rd_second;
            // beats 0 and 2 leave on the following k_clk_n rise
            if (rd_first)
                kn_stage_reg <= mem[{ra_reg[ofs], `DDRP_BEAT0}];
            else if (rd_second)
                kn_stage_reg <= mem[{ra_reg[ofs + 2'h1], `DDRP_BEAT2}];
            if (rd_second)
                q_k_reg <= mem[{ra_reg[ofs + 2'h1], `DDRP_BEAT1}];
            else if (rd_third)
                q_k_reg <= mem[{ra_reg[ofs + 2'h2], `DDRP_BEAT3}];
        end
    end

    // ============================================================
    // complementary clock rise: odd write beats, even read beats
    logic [DW-1:0] od_d_reg;
    logic [BW-1:0] od_bw_reg;

    always_ff @(posedge k_clk_n or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            od_d_reg <= '0;
            od_bw_reg <= '1;
            q_kn_reg <= '0;
            valid_kn_reg <= 1'h0;
        end
        else
        begin
            od_d_reg <= data_io_in;
            od_bw_reg <= byte_write_n;
            // half-cycle hand-off from k_clk relies on 180 degree phase
            q_kn_reg <= kn_stage_reg;
            valid_kn_reg <= kn_vstage_reg;
        end
    end

    // ============================================================
    // pins: outputs follow whichever clock rose last
    assign echo_clk_true = k_clk;
    assign echo_clk_comp = k_clk_n;
    assign data_io_out = k_clk ? q_k_reg : q_kn_reg;
    assign out_valid_flag = k_clk ? valid_k_reg : valid_kn_reg;
    assign data_io_oe = k_clk ? valid_k_reg : valid_kn_reg;

    // ============================================================
    // write beat capture, one pair pushed per cycle
    logic [2:0] wsh_reg;
    logic [AW-1:0] wa1_reg;
    logic [AW-1:0] wa2_reg;
    logic [DW-1:0] ev_d_reg;
    logic [BW-1:0] ev_bw_reg;
    logic push_half;

    always_ff @(posedge k_clk or negedge k_rst_n)
    begin
        if (!k_rst_n)
        begin
            wsh_reg <= 3'h0;
            wa1_reg <= '0;
            wa2_reg <= '0;
            ev_d_reg <= '0;
            ev_bw_reg <= '1;
        end
        else
        begin
            wsh_reg <= {wsh_reg[1:0], wr_issue};
            wa1_reg <= ra_reg[0];
            wa2_reg <= wa1_reg;
            // late write: even beats one and two cycles after command
            if (wsh_reg[0] || wsh_reg[1])
            begin
                ev_d_reg <= data_io_in;
                ev_bw_reg <= byte_write_n;
            end
        end
    end

    ddrp_stream_if #(.W(WW)) wq_in ();
    ddrp_stream_if #(.W(WW)) wq_out ();

    assign push_half = wsh_reg[2];
    assign wq_in.valid = wsh_reg[1] || wsh_reg[2];
    assign wq_in.data = {push_half ? wa2_reg : wa1_reg, push_half,
        ev_d_reg, ev_bw_reg, od_d_reg, od_bw_reg};
    // a pair offered while full is lost; the pin warns the system
    assign wr_buf_ready = wq_in.ready;
    // the array has one access slot, reads win it
    assign wq_out.ready = !rd_fetch;

    ddrp_fifo #(
        .W(WW),
        .DEPTH(FIFO_DEPTH)
    ) u_wbuf (
        .clk(k_clk),
        .rst_n(k_rst_n),
        .fill(wq_in),
        .drain(wq_out)
    );

    // ============================================================
    // array write with per-lane merge
    logic [AW-1:0] d_addr;
    logic d_half;
    logic [DW-1:0] d_ev;
    logic [DW-1:0] d_od;
    logic [BW-1:0] d_ev_bw;
    logic [BW-1:0] d_od_bw;
    logic [AW+1:0] d_ev_idx;
    logic [AW+1:0] d_od_idx;
    logic [DW-1:0] ev_merge;
    logic [DW-1:0] od_merge;

    assign {d_addr, d_half, d_ev, d_ev_bw, d_od, d_od_bw} = wq_out.data;
    assign d_ev_idx = {d_addr, d_half, `DDRP_EVEN};
    assign d_od_idx = {d_addr, d_half, `DDRP_ODD};

    // lane width fixes the bus at 18 or 36 bits by parameter
    for (genvar g = 0; g < BW; g++)
    begin : g_lane
        assign ev_merge[g*LW +: LW] = d_ev_bw[g] ?
            mem[d_ev_idx][g*LW +: LW] : d_ev[g*LW +: LW];
        assign od_merge[g*LW +: LW] = d_od_bw[g] ?
            mem[d_od_idx][g*LW +: LW] : d_od[g*LW +: LW];
    end

    // reads of a burst still buffered return old data
    always_ff @(posedge k_clk)
    begin
        if (wq_out.valid && wq_out.ready)
        begin
            mem[d_ev_idx] <= ev_merge;
            mem[d_od_idx] <= od_merge;
        end
    end

    // ============================================================
    // checks
    a_read_full_lat:
    assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        rd_issue && mode_reg |-> ##3 kn_vstage_reg
            ##1 (kn_vstage_reg && valid_k_reg) ##1 valid_k_reg
    ) else $error("full latency read beats misplaced");

    a_read_short_lat:
    assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        rd_issue && !mode_reg |-> ##2 kn_vstage_reg
            ##1 (kn_vstage_reg && valid_k_reg) ##1 valid_k_reg
    ) else $error("bypass latency read beats misplaced");

    a_cmd_edge:
    assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        rsh_reg[0] |-> $past(!load_cycle_n && rw_sel)
    ) else $error("read started without a load on the true rise");

    a_addr_hold:
    assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        load_cycle_n |=> ra_reg[0] == $past(ra_reg[0])
    ) else $error("address changed without a load");

    a_write_pairs:
    assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        wr_issue |-> ##2 (wq_in.valid && !push_half)
            ##1 (wq_in.valid && push_half)
    ) else $error("write beat pairs not offered in order");

    a_mode_follow:
    assert property (
        @(posedge k_clk) disable iff (!k_rst_n)
        rsh_reg == '0 && !rd_issue && !lock_sync_reg[1] |=> !mode_reg
    ) else $error("full latency kept without dll lock");

    a_dll_bypass:
    assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !doff_sync_reg[1] |=>
            dll_state_reg == ddrp_dll_bypass && !dll_lock_reg
    ) else $error("dll not bypassed while control low");

    a_lock_time:
    assert property (
        @(posedge ref_clk) disable iff (!rstn)
        $rose(dll_lock_reg) |-> $past(lock_cnt_reg) == LCW'(LOCK_CYCLES - 1)
    ) else $error("dll lock reported before lock time");

    c_read_full: cover property (
        @(posedge k_clk) disable iff (!k_rst_n) rd_issue && mode_reg
    );

    c_read_short: cover property (
        @(posedge k_clk) disable iff (!k_rst_n) rd_issue && !mode_reg
    );

    c_write_burst: cover property (
        @(posedge k_clk) disable iff (!k_rst_n)
        wr_issue ##3 (wq_out.valid && wq_out.ready)
    );
endmodule : ddrp_port

// >>> verification/ddrp_host_model.sv
// ddrp_host_model: controller-side model driving the sram port pins
`include "ddrp_defines.svh"
module ddrp_host_model
#(
    parameter int DW = 36,
    parameter int AW = 4
)
(
    // input clock pair
    output logic k_clk,
    output logic k_clk_n,
    // command pins
    output logic load_cycle_n,
    output logic rw_sel,
    output logic [AW-1:0] addr_in,
    // shared bus as seen by the device, and byte strobes
    output logic [DW-1:0] data_io_in,
    output logic [DW/`DDRP_LANE_W-1:0] byte_write_n,
    // device read side
    input wire logic [DW-1:0] data_io_out,
    input wire logic data_io_oe,
    input wire logic out_valid_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NL = DW / `DDRP_LANE_W;
    logic host_oe;
    logic [DW-1:0] drv;
    int hs;
    int bcnt;
    int ld_q[$];
    int lat_q[$];
    logic [DW-1:0] rd_q[$];

    // ============================================================
    // clocks, pins at rest
    initial
    begin
        host_oe = 1'b0;
        drv = '0;
        load_cycle_n = 1'b1;
        rw_sel = 1'b0;
        addr_in = '0;
        byte_write_n = '1;
        k_clk = 1'b0;
        #7;
        forever #15 k_clk = ~k_clk;
    end
    assign k_clk_n = ~k_clk;

    // released bus toggles so a stale value never reads as good data
    always @(posedge k_clk or posedge k_clk_n)
        if (!host_oe)
            drv <= ~drv;
    assign data_io_in = data_io_oe ? data_io_out : drv;

    // ============================================================
    // read capture, half a phase after each rising edge
    always @(posedge k_clk or posedge k_clk_n)
    begin
        hs++;
        #7;
        if (out_valid_flag === 1'b1)
        begin
            if (bcnt == 0)
                lat_q.push_back(hs - ld_q.pop_front());
            rd_q.push_back(data_io_in);
            bcnt = (bcnt + 1) % 4;
        end
    end

    // ============================================================
    // bus cycles
    task automatic idle(input int n);
        repeat (n) @(posedge k_clk);
    endtask : idle

    // dbl keeps load low one more rise, as a write of b
    task automatic rd(input logic [AW-1:0] a, input logic [AW-1:0] b,
        input bit dbl);
        @(posedge k_clk);
        #2;
        load_cycle_n = 1'b0;
        rw_sel = 1'b1;
        addr_in = a;
        // taken at the next true rise, two half edges on
        ld_q.push_back(hs + 2);
        @(posedge k_clk);
        #2;
        load_cycle_n = !dbl;
        rw_sel = 1'b0;
        addr_in = b;
        if (dbl)
        begin
            @(posedge k_clk);
            #2;
            load_cycle_n = 1'b1;
        end
    endtask : rd

    task automatic wr(input logic [AW-1:0] a, input logic [4*DW-1:0] d,
        input logic [4*NL-1:0] m);
        @(posedge k_clk);
        #2;
        load_cycle_n = 1'b0;
        rw_sel = 1'b0;
        addr_in = a;
        @(posedge k_clk);
        #2;
        load_cycle_n = 1'b1;
        addr_in = ~a;
        @(posedge k_clk_n);
        #2;
        host_oe = 1'b1;
        drv = d[0+:DW];
        byte_write_n = m[0+:NL];
        // later beats run on so the next load can follow two rises later
        fork
        begin
            @(posedge k_clk);
            #2;
            drv = d[DW+:DW];
            byte_write_n = m[NL+:NL];
            @(posedge k_clk_n);
            #2;
            drv = d[2*DW+:DW];
            byte_write_n = m[2*NL+:NL];
            @(posedge k_clk);
            #2;
            drv = d[3*DW+:DW];
            byte_write_n = m[3*NL+:NL];
            @(posedge k_clk_n);
            #1;
            host_oe = 1'b0;
            byte_write_n = '1;
        end
        join_none
    endtask : wr
endmodule : ddrp_host_model

// >>> verification/tb_ddr_burst4_sram_port.sv
// tb_ddr_burst4_sram_port: self-checking bench of the sram port
`include "ddrp_defines.svh"
module tb_ddr_burst4_sram_port;
    timeunit 1ns;
    timeprecision 1ps;
    import ddrp_pkg::*;
    localparam int DW = 36;
    localparam int AW = 4;
    localparam int NL = DW / `DDRP_LANE_W;
    localparam int LOCK = 8;
    localparam int NB = 2 ** AW;
    logic ref_clk;
    logic rstn;
    logic dll_off_n;
    logic k_clk;
    logic k_clk_n;
    logic load_cycle_n;
    logic rw_sel;
    logic [AW-1:0] addr_in;
    logic [DW-1:0] data_io_in;
    logic [DW-1:0] data_io_out;
    logic data_io_oe;
    logic [NL-1:0] byte_write_n;
    logic echo_clk_true;
    logic echo_clk_comp;
    logic out_valid_flag;
    ddrp_dll_state_t dll_status;
    logic wr_buf_ready;
    logic [DW-1:0] mem [0:4*NB-1];
    logic [AW-1:0] exp_q[$];
    integer seed;
    int bad_count;
    int compares;
    int n;
    logic saw;

    ddrp_port #(.DW(DW), .AW(AW), .LOCK_CYCLES(LOCK)) u_dut
    (
        .ref_clk(ref_clk), .rstn(rstn), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .load_cycle_n(load_cycle_n), .rw_sel(rw_sel), .addr_in(addr_in),
        .data_io_in(data_io_in), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe), .byte_write_n(byte_write_n),
        .echo_clk_true(echo_clk_true), .echo_clk_comp(echo_clk_comp),
        .out_valid_flag(out_valid_flag), .dll_off_n(dll_off_n),
        .dll_status(dll_status), .wr_buf_ready(wr_buf_ready)
    );

    ddrp_host_model u_host
    (
        .k_clk(k_clk), .k_clk_n(k_clk_n), .load_cycle_n(load_cycle_n),
        .rw_sel(rw_sel), .addr_in(addr_in), .data_io_in(data_io_in),
        .byte_write_n(byte_write_n), .data_io_out(data_io_out),
        .data_io_oe(data_io_oe), .out_valid_flag(out_valid_flag)
    );

    always #20 ref_clk = ~ref_clk;

    // ============================================================
    // checking helpers
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h, expected %h",
                $time, seen, exp);
        end
    endtask : check

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
        input logic [DW-1:0] d, input logic [NL-1:0] m);
        for (int i = 0; i < NL; i++)
            if (!m[i])
                o[i*`DDRP_LANE_W+:`DDRP_LANE_W] =
                    d[i*`DDRP_LANE_W+:`DDRP_LANE_W];
        return o;
    endfunction : merge

    task automatic do_wr(input logic [AW-1:0] a, input bit rnd_mask);
        logic [4*DW-1:0] d;
        logic [4*NL-1:0] m;
        for (int i = 0; i < 4; i++)
        begin
            d[i*DW+:DW] = {$random(seed), $random(seed)};
            m[i*NL+:NL] = rnd_mask ? NL'($random(seed)) : '0;
            mem[{a, 2'(i)}] = merge(mem[{a, 2'(i)}], d[i*DW+:DW],
                m[i*NL+:NL]);
        end
        u_host.wr(a, d, m);
    endtask : do_wr

    task automatic do_rd(input logic [AW-1:0] a, input bit dbl);
        u_host.rd(a, a ^ 4'h9, dbl);
        exp_q.push_back(a);
    endtask : do_rd

    task automatic drain(input int lat);
        logic [AW-1:0] a;
        u_host.idle(8);
        check(u_host.rd_q.size(), 4 * exp_q.size());
        while (exp_q.size() > 0)
        begin
            a = exp_q.pop_front();
            check(u_host.lat_q.pop_front(), lat);
            for (int i = 0; i < 4; i++)
                check(u_host.rd_q.pop_front(), mem[{a, 2'(i)}]);
        end
    endtask : drain

    task automatic close_out();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    // echo clocks free running, flag matches bus drive
    always @(posedge k_clk or negedge k_clk)
    begin
        #5;
        check(echo_clk_true, k_clk);
        check(echo_clk_comp, k_clk_n);
        check(out_valid_flag, data_io_oe);
    end

    initial
    begin
        #300000;
        bad_count++;
        close_out();
    end

    // ============================================================
    // main sequence
    initial
    begin
        seed = 32'he6ac;
        bad_count = 0;
        compares = 0;
        ref_clk = 1'b0;
        rstn = 1'b0;
        dll_off_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #2;
        rstn = 1'b1;
        check(dll_status, ddrp_dll_bypass);
        check(wr_buf_ready, 1'b1);
        u_host.idle(4);
        // bypass: fill every burst back to back, read some back
        for (int b = 0; b < NB; b++)
            do_wr(AW'(b), 1'b0);
        u_host.idle(10);
        for (int b = 0; b < 4; b++)
            do_rd(AW'(b), 1'b0);
        drain(3);
        $display("test bypass latency done");
        @(posedge ref_clk);
        #2;
        dll_off_n = 1'b1;
        saw = 1'b0;
        n = 0;
        while (dll_status !== ddrp_dll_locked && n < LOCK + 20)
        begin
            @(posedge ref_clk);
            #2;
            n++;
            if (dll_status === ddrp_dll_locking)
                saw = 1'b1;
        end
        check(saw, 1'b1);
        check(n >= LOCK && n <= LOCK + 4, 1'b1);
        $display("test dll lock done");
        u_host.idle(6);
        // random bursts with random byte strobes
        for (int k = 0; k < 24; k++)
            do_wr(AW'($random(seed)), 1'b1);
        u_host.idle(10);
        for (int b = 0; b < NB; b++)
            do_rd(AW'(b), 1'b0);
        drain(5);
        $display("test full latency done");
        // a load one rise after a read must be ignored
        do_rd(4'h3, 1'b1);
        drain(5);
        do_rd(4'ha, 1'b0);
        drain(5);
        $display("test early load done");
        @(posedge ref_clk);
        #2;
        dll_off_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        #2;
        check(dll_status, ddrp_dll_bypass);
        u_host.idle(6);
        do_rd(4'h0, 1'b0);
        drain(3);
        $display("test dll off done");
        close_out();
    end
endmodule : tb_ddr_burst4_sram_port
